// ==== src/prha_pkg.sv ====
// Behaviour
// - Keep the last twelve samples, two bytes each, in a 24-byte rolling buffer.
// - An 8-bit index always holds the address of the last byte written.
// - Buffer spans 0x76 to 0x8D; bytes never written read as zero.
// - Store ascending, MSB first; after the top byte wrap to the bottom.
// - On attention: supply switch if enabled, notify pulse, then PWM until wake or 2048 ms.
// - Normal mode without attention: four PWM periods, then sleep; wake low ends them early.
// - PWM near 100 Hz with 8 us high-time resolution.
// - Duty is active time over period; a polarity bit picks the active level.
// - Any ADC, self-test or firmware error forces 95 % duty.
// - Underflow code gives 10 % duty.
// - Overflow code gives 90 % duty.
// - Valid code gives duty (count + 128) / 1280.
// - Wake pin low requests access; device asserts ready when it can take transfers.
// - A polarity bit selects the active level of the ready/notify pin.
// - After ready, set the halt register; stay halted at most 2048 ms.
// - Bit 2 of the halt register reads one when ready for transfers.
// - Select low without clocks flags a fault; next frame only clears it.
// - Host clears halt last; device resumes, drops ready, then disables the port.
// - Without a host clear, the halt timeout resumes the device.
// - Wake low during event PWM stops PWM, enables the port, asserts ready.
package prha_pkg;

    localparam int CLK_MHZ         = 250;
    localparam int PWM_RES_US      = 8;
    localparam int TICK_CYC        = PWM_RES_US * CLK_MHZ;
    localparam int HALT_TMO_MS     = 2048;
    localparam int HALT_TMO_CYC    = HALT_TMO_MS * 1000 * CLK_MHZ;
    localparam int SUPPLY_WAIT_MS  = 200;
    localparam int SUPPLY_WAIT_CYC = SUPPLY_WAIT_MS * 1000 * CLK_MHZ;
    localparam int NOTIFY_US       = 1000;
    localparam int NOTIFY_CYC      = NOTIFY_US * CLK_MHZ;
    localparam int TMR_W           = 30;
    localparam int PRE_W           = 11;
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYC - 1);

    // Duty math in 8 us ticks; a 1280-tick period keeps the formula exact
    localparam int DUTY_W = 11;
    localparam logic [DUTY_W-1:0] DUTY_SCALE  = 11'h500;
    localparam logic [DUTY_W-1:0] DUTY_OFFSET = 11'h080;
    localparam logic [DUTY_W-1:0] TICK_LAST   = DUTY_SCALE - 11'h001;
    localparam logic [DUTY_W-1:0] DUTY_ERR    = DUTY_W'(1280 * 95 / 100);
    localparam logic [DUTY_W-1:0] DUTY_UNDER  = DUTY_W'(1280 * 10 / 100);
    localparam logic [DUTY_W-1:0] DUTY_OVER   = DUTY_W'(1280 * 90 / 100);

    localparam int PCODE_W = 10;
    localparam logic [PCODE_W-1:0] P_UNDER_CODE = 10'h000;
    localparam logic [PCODE_W-1:0] P_OVER_CODE  = 10'h3FF;

    localparam int BUF_BYTES = 24;
    localparam logic [7:0] BUF_BASE = 8'h76;
    localparam logic [7:0] BUF_TOP  = 8'h8D;
    localparam logic [7:0] IDX_RST  = 8'h8D;
    localparam logic [7:0] HALT_ADDR = 8'h20;
    localparam logic [7:0] IDX_ADDR  = 8'h21;
    localparam int HALT_BIT  = 0;
    localparam int READY_BIT = 2;

    localparam logic [4:0] FRAME_LAST   = 5'h0F;
    localparam logic [1:0] NORMAL_LAST  = 2'h3;
    localparam logic [2:0] SYNC_RST     = 3'h4;

    typedef struct packed {
        logic supply_en;
        logic pwm_pol;
        logic notify_pol;
        logic normal_mode;
    } prha_cfg_t;

    typedef struct packed {
        logic adc;
        logic self_test;
        logic fw_verify;
    } prha_err_t;

    typedef enum logic [2:0] {
        ST_SLEEP,
        ST_NORMAL_PWM,
        ST_SUPPLY_WAIT,
        ST_NOTIFY,
        ST_EVT_PWM,
        ST_WAKE,
        ST_HALTED,
        ST_RESUME
    } prha_state_t;

endpackage

// ==== src/prha_pwm.sv ====
module prha_pwm
    import prha_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_run,
    input  wire logic [DUTY_W-1:0] i_duty,
    input  wire logic              i_pol,
    output logic                   o_pwm,
    output logic                   o_period_end
);

    logic [PRE_W-1:0]  pre_ff;
    logic [PRE_W-1:0]  nxt_pre;
    logic [DUTY_W-1:0] tick_ff;
    logic [DUTY_W-1:0] nxt_tick;
    logic [DUTY_W-1:0] duty_ff;
    logic [DUTY_W-1:0] nxt_duty;
    logic              pwm_ff;
    logic              nxt_pwm;
    logic              end_ff;
    logic              nxt_end;

    always_comb begin
        nxt_pre  = pre_ff;
        nxt_tick = tick_ff;
        nxt_duty = duty_ff;
        nxt_end  = 1'b0;
        if (!i_run) begin
            nxt_pre  = '0;
            nxt_tick = '0;
            nxt_duty = i_duty;
        end else if (pre_ff == PRE_LAST) begin
            nxt_pre = '0;
            if (tick_ff == TICK_LAST) begin
                nxt_tick = '0;
                nxt_end  = 1'b1;
                // Duty taken only at period start to avoid runt pulses
                nxt_duty = i_duty;
            end else begin
                nxt_tick = tick_ff + 11'h001;
            end
        end else begin
            nxt_pre = pre_ff + 11'h001;
        end
        nxt_pwm = (i_run && (tick_ff < duty_ff)) ~^ i_pol;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            pre_ff  <= '0;
            tick_ff <= '0;
            duty_ff <= '0;
            pwm_ff  <= 1'b0;
            end_ff  <= 1'b0;
        end else begin
            pre_ff  <= nxt_pre;
            tick_ff <= nxt_tick;
            duty_ff <= nxt_duty;
            pwm_ff  <= nxt_pwm;
            end_ff  <= nxt_end;
        end
    end

    assign o_pwm        = pwm_ff;
    assign o_period_end = end_ff;

endmodule

// ==== src/prha_top.sv ====
module prha_top
    import prha_pkg::*;
#(
    parameter int HALT_CYC   = HALT_TMO_CYC,
    parameter int SUPPLY_CYC = SUPPLY_WAIT_CYC,
    parameter int PULSE_CYC  = NOTIFY_CYC
) (
    input  wire logic               I_CLK,
    input  wire logic               I_RST_N,
    input  wire prha_cfg_t          I_CFG,
    input  wire prha_err_t          I_ERR,
    input  wire logic               I_SAMPLE_VALID,
    input  wire logic [PCODE_W-1:0] I_SAMPLE_CODE,
    input  wire logic               I_PERIOD_DONE,
    input  wire logic               I_ATTN,
    input  wire logic               I_CS_N,
    input  wire logic               I_SCLK,
    input  wire logic               I_MOSI,
    output logic                    O_PWM,
    output logic                    O_NOTIFY,
    output logic                    O_SUPPLY_SWITCH_ON,
    output logic                    O_SPI_EN,
    output logic                    O_SLEEP,
    output logic                    O_HALTED,
    output logic                    O_MISO,
    output logic [7:0]              O_BUF_LAST_IDX
);

    localparam logic [TMR_W-1:0] HALT_LAST   = TMR_W'(HALT_CYC - 1);
    localparam logic [TMR_W-1:0] SUPPLY_LAST = TMR_W'(SUPPLY_CYC - 1);
    localparam logic [TMR_W-1:0] PULSE_LAST  = TMR_W'(PULSE_CYC - 1);

    // Pin synchroniser: {cs_n, sclk, mosi}
    logic [2:0] meta_ff;
    logic [2:0] sync_ff;
    logic [2:0] prev_ff;
    logic [2:0] nxt_meta;
    logic [2:0] nxt_sync;
    logic [2:0] nxt_prev;
    logic       cs_n;
    logic       mosi;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       cs_fall;
    logic       cs_rise;

    always_comb begin
        nxt_meta = {I_CS_N, I_SCLK, I_MOSI};
        nxt_sync = meta_ff;
        nxt_prev = sync_ff;
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            meta_ff <= SYNC_RST;
            sync_ff <= SYNC_RST;
            prev_ff <= SYNC_RST;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
            prev_ff <= nxt_prev;
        end
    end

    assign cs_n      = sync_ff[2];
    assign mosi      = sync_ff[0];
    assign sclk_rise = sync_ff[1] & ~prev_ff[1] & ~cs_n;
    assign sclk_fall = ~sync_ff[1] & prev_ff[1] & ~cs_n;
    assign cs_fall   = ~cs_n & prev_ff[2];
    assign cs_rise   = cs_n & ~prev_ff[2];

    // Buffer state
    logic [7:0]         mem_ff [BUF_BYTES];
    logic [7:0]         nxt_mem [BUF_BYTES];
    logic [7:0]         idx_ff;
    logic [7:0]         nxt_idx;
    logic [PCODE_W-1:0] code_ff;
    logic [PCODE_W-1:0] nxt_code;

    // Control state
    prha_state_t        state_ff;
    prha_state_t        nxt_state;
    logic [TMR_W-1:0]   tmr_ff;
    logic [TMR_W-1:0]   nxt_tmr;
    logic [1:0]         per_ff;
    logic [1:0]         nxt_per;
    logic               supply_ff;
    logic               nxt_supply;
    logic               spi_en_ff;
    logic               nxt_spi_en;
    logic               halt_ff;
    logic               nxt_halt;
    logic               ready_ff;
    logic               nxt_ready;
    logic               notify_ff;
    logic               nxt_notify;
    logic               sleep_ff;
    logic               nxt_sleep;
    logic               run_ff;
    logic               nxt_run;
    logic [DUTY_W-1:0]  duty_ff;
    logic [DUTY_W-1:0]  nxt_duty;
    logic               period_end;

    // Serial port state
    logic [15:0]        rx_ff;
    logic [15:0]        nxt_rx;
    logic [4:0]         bits_ff;
    logic [4:0]         nxt_bits;
    logic               seen_ff;
    logic               nxt_seen;
    logic               fault_ff;
    logic               nxt_fault;
    logic [15:0]        tx_ff;
    logic [15:0]        nxt_tx;
    logic               miso_ff;
    logic               nxt_miso;
    logic               halt_clr;
    logic [15:0]        word;

    function automatic logic [4:0] buf_off(input logic [7:0] a);
        logic [7:0] d;
        d = a - BUF_BASE;
        return d[4:0];
    endfunction

    function automatic logic [7:0] rd_byte(input logic [7:0] a);
        logic [7:0] r;
        r = '0;
        if (a >= BUF_BASE && a <= BUF_TOP) begin
            r = mem_ff[buf_off(a)];
        end else if (a == IDX_ADDR) begin
            r = idx_ff;
        end else if (a == HALT_ADDR) begin
            r[HALT_BIT] = halt_ff;
            r[READY_BIT] = ready_ff;
        end
        return r;
    endfunction

    function automatic logic [DUTY_W-1:0] duty_sel(input prha_err_t e, input logic [PCODE_W-1:0] c);
        logic [DUTY_W-1:0] d;
        d = {1'b0, c} + DUTY_OFFSET;
        if (e.adc || e.self_test || e.fw_verify) begin
            d = DUTY_ERR;
        end else if (c == P_UNDER_CODE) begin
            d = DUTY_UNDER;
        end else if (c == P_OVER_CODE) begin
            d = DUTY_OVER;
        end
        return d;
    endfunction

    // Sample buffer
    always_comb begin
        logic [7:0] base;
        base     = '0;
        nxt_mem  = mem_ff;
        nxt_idx  = idx_ff;
        nxt_code = code_ff;
        // Samples arriving while halted are dropped, not queued
        if (I_SAMPLE_VALID && !halt_ff) begin
            base = (idx_ff == BUF_TOP) ? BUF_BASE : idx_ff + 8'h01;
            nxt_mem[buf_off(base)]         = {6'h00, I_SAMPLE_CODE[9:8]};
            nxt_mem[buf_off(base) + 5'h01] = I_SAMPLE_CODE[7:0];
            nxt_idx  = base + 8'h01;
            nxt_code = I_SAMPLE_CODE;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            mem_ff  <= '{default: 8'h00};
            idx_ff  <= IDX_RST;
            code_ff <= '0;
        end else begin
            mem_ff  <= nxt_mem;
            idx_ff  <= nxt_idx;
            code_ff <= nxt_code;
        end
    end

    // Sequencer
    always_comb begin
        nxt_state  = state_ff;
        nxt_tmr    = tmr_ff + 30'h00000001;
        nxt_per    = per_ff;
        nxt_supply = supply_ff;
        nxt_spi_en = spi_en_ff;
        nxt_halt   = halt_ff;
        nxt_ready  = ready_ff;
        nxt_duty   = duty_sel(I_ERR, code_ff);
        unique case (state_ff)
            ST_SLEEP: begin
                // Wake on the falling edge, so a held select cannot re-wake
                if (cs_fall) begin
                    nxt_state = ST_WAKE;
                end else if (I_PERIOD_DONE && I_ATTN) begin
                    nxt_supply = I_CFG.supply_en;
                    nxt_state  = I_CFG.supply_en ? ST_SUPPLY_WAIT : ST_NOTIFY;
                end else if (I_PERIOD_DONE && I_CFG.normal_mode) begin
                    nxt_state = ST_NORMAL_PWM;
                    nxt_per   = '0;
                end
            end
            ST_NORMAL_PWM: begin
                if (cs_fall) begin
                    nxt_state = ST_WAKE;
                end else if (period_end) begin
                    if (per_ff == NORMAL_LAST) begin
                        nxt_state = ST_SLEEP;
                    end else begin
                        nxt_per = per_ff + 2'h1;
                    end
                end
            end
            ST_SUPPLY_WAIT: begin
                if (tmr_ff == SUPPLY_LAST) begin
                    nxt_state = ST_NOTIFY;
                end
            end
            ST_NOTIFY: begin
                if (tmr_ff == PULSE_LAST) begin
                    nxt_state = ST_EVT_PWM;
                end
            end
            ST_EVT_PWM: begin
                if (cs_fall) begin
                    nxt_state = ST_WAKE;
                end else if (tmr_ff == HALT_LAST) begin
                    nxt_state = ST_SLEEP;
                end
            end
            ST_WAKE: begin
                nxt_spi_en = 1'b1;
                nxt_ready  = 1'b1;
                nxt_state  = ST_HALTED;
            end
            ST_HALTED: begin
                nxt_halt = 1'b1;
                if (halt_clr && halt_ff) begin
                    nxt_state = ST_RESUME;
                end else if (tmr_ff == HALT_LAST) begin
                    nxt_state = ST_RESUME;
                end
                if (nxt_state == ST_RESUME) begin
                    nxt_halt  = 1'b0;
                    nxt_ready = 1'b0;
                end
            end
            ST_RESUME: begin
                nxt_spi_en = 1'b0;
                nxt_state  = ST_SLEEP;
            end
        endcase
        if (nxt_state != state_ff) begin
            nxt_tmr = '0;
        end
        if (nxt_state == ST_SLEEP) begin
            nxt_supply = 1'b0;
        end
        nxt_run    = (nxt_state == ST_NORMAL_PWM) || (nxt_state == ST_EVT_PWM);
        nxt_sleep  = (nxt_state == ST_SLEEP);
        nxt_notify = ((nxt_state == ST_NOTIFY) || nxt_ready) ~^ I_CFG.notify_pol;
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            state_ff  <= ST_SLEEP;
            tmr_ff    <= '0;
            per_ff    <= '0;
            supply_ff <= 1'b0;
            spi_en_ff <= 1'b0;
            halt_ff   <= 1'b0;
            ready_ff  <= 1'b0;
            notify_ff <= 1'b0;
            sleep_ff  <= 1'b1;
            run_ff    <= 1'b0;
            duty_ff   <= '0;
        end else begin
            state_ff  <= nxt_state;
            tmr_ff    <= nxt_tmr;
            per_ff    <= nxt_per;
            supply_ff <= nxt_supply;
            spi_en_ff <= nxt_spi_en;
            halt_ff   <= nxt_halt;
            ready_ff  <= nxt_ready;
            notify_ff <= nxt_notify;
            sleep_ff  <= nxt_sleep;
            run_ff    <= nxt_run;
            duty_ff   <= nxt_duty;
        end
    end

    prha_pwm u_pwm (
        .i_clk        (I_CLK),
        .i_rst_n      (I_RST_N),
        .i_run        (run_ff),
        .i_duty       (duty_ff),
        .i_pol        (I_CFG.pwm_pol),
        .o_pwm        (O_PWM),
        .o_period_end (period_end)
    );

    // Serial port: frame is {address, data}, MSB first
    assign word = {rx_ff[14:0], mosi};

    always_comb begin
        nxt_rx    = rx_ff;
        nxt_bits  = bits_ff;
        nxt_seen  = seen_ff;
        nxt_fault = fault_ff;
        nxt_tx    = tx_ff;
        halt_clr  = 1'b0;
        if (cs_fall) begin
            nxt_bits = '0;
            nxt_seen = 1'b0;
        end
        // Trailing fall after the last bit must not shift
        if (sclk_fall && bits_ff != 5'h00) begin
            nxt_tx = {tx_ff[14:0], 1'b0};
        end
        if (sclk_rise) begin
            nxt_rx   = word;
            nxt_seen = 1'b1;
            nxt_bits = bits_ff + 5'h01;
            if (bits_ff == FRAME_LAST) begin
                nxt_bits = '0;
                nxt_tx   = '0;
                if (fault_ff) begin
                    nxt_fault = 1'b0;
                end else if (spi_en_ff) begin
                    nxt_tx = {word[15:8], rd_byte(word[15:8])};
                    if (word[15:8] == HALT_ADDR && !word[HALT_BIT]) begin
                        halt_clr = 1'b1;
                    end
                end
            end
        end
        // Disabled port answers zero, no stale word
        if (!spi_en_ff) begin
            nxt_tx = '0;
        end
        if (cs_rise && !seen_ff) begin
            nxt_fault = 1'b1;
        end
        nxt_miso = spi_en_ff & ~cs_n & nxt_tx[15];
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            rx_ff    <= '0;
            bits_ff  <= '0;
            seen_ff  <= 1'b0;
            fault_ff <= 1'b0;
            tx_ff    <= '0;
            miso_ff  <= 1'b0;
        end else begin
            rx_ff    <= nxt_rx;
            bits_ff  <= nxt_bits;
            seen_ff  <= nxt_seen;
            fault_ff <= nxt_fault;
            tx_ff    <= nxt_tx;
            miso_ff  <= nxt_miso;
        end
    end

    assign O_NOTIFY           = notify_ff;
    assign O_SUPPLY_SWITCH_ON = supply_ff;
    assign O_SPI_EN           = spi_en_ff;
    assign O_SLEEP            = sleep_ff;
    assign O_HALTED           = halt_ff;
    assign O_MISO             = miso_ff;
    assign O_BUF_LAST_IDX     = idx_ff;

endmodule

// ==== verification/prha_host_model.sv ====
module prha_host_model (
    input  wire logic i_miso,
    input  wire logic i_ready_pin,
    input  wire logic i_ready_pol,
    output logic      o_cs_n,
    output logic      o_sclk,
    output logic      o_mosi
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HALF_NS = 24;

    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_mosi = 1'b1;
    end

    task automatic wake(output logic ok);
        int k;
        o_cs_n = 1'b0;
        ok = 1'b0;
        for (k = 0; k < 2000 && !ok; k++) begin
            #4;
            ok = (i_ready_pin === i_ready_pol);
        end
        o_cs_n = 1'b1;
        #(HALF_NS);
    endtask

    // Mode 0, MSB first; clock idles low
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        int b;
        o_cs_n = 1'b0;
        for (b = 15; b >= 0; b--) begin
            o_mosi = tx[b];
            #(HALF_NS);
            o_sclk = 1'b1;
            rx[b] = i_miso;
            #(HALF_NS);
            o_sclk = 1'b0;
        end
        #(HALF_NS);
        o_cs_n = 1'b1;
        // Released line must not keep the last bit
        o_mosi = ~tx[0];
        #(HALF_NS);
    endtask
endmodule

// ==== verification/prha_monitor.sv ====
module prha_monitor
    import prha_pkg::*;
#(
    parameter int HALT_CYC = HALT_TMO_CYC
) (
    input  wire logic       I_CLK,
    input  wire logic       I_RST_N,
    input  wire prha_cfg_t  I_CFG,
    input  wire logic       I_SAMPLE_VALID,
    input  wire logic       I_PERIOD_DONE,
    input  wire logic       I_ATTN,
    input  wire logic       O_PWM,
    input  wire logic       O_NOTIFY,
    input  wire logic       O_SUPPLY_SWITCH_ON,
    input  wire logic       O_SPI_EN,
    input  wire logic       O_SLEEP,
    input  wire logic       O_HALTED,
    input  wire logic [7:0] O_BUF_LAST_IDX
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] halt_cnt_ff;
    logic [31:0] nxt_halt_cnt;
    wire         ready_on = (O_NOTIFY == I_CFG.notify_pol);

    // Cycles spent halted, cleared on resume
    always_comb begin
        nxt_halt_cnt = O_HALTED ? halt_cnt_ff + 32'h1 : 32'h0;
    end
    always_ff @(posedge I_CLK) begin
        halt_cnt_ff <= I_RST_N ? nxt_halt_cnt : 32'h0;
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);

    a_idx_step:
    assert property (I_SAMPLE_VALID && !O_HALTED |=> O_BUF_LAST_IDX ==
        (($past(O_BUF_LAST_IDX) == 8'h8D) ? 8'h77 : $past(O_BUF_LAST_IDX) + 8'h02)) else $error("index step");
    a_idx_hold:
    assert property (!I_SAMPLE_VALID || O_HALTED |=> $stable(O_BUF_LAST_IDX)) else $error("index moved");
    a_idx_range:
    assert property (O_BUF_LAST_IDX[0] && O_BUF_LAST_IDX >= 8'h77 && O_BUF_LAST_IDX <= 8'h8D)
        else $error("index range");
    a_halt_after:
    assert property ($rose(O_HALTED) |-> $past(ready_on) && O_SPI_EN) else $error("halt before ready");
    a_halt_ready:
    assert property (O_HALTED |-> ready_on && O_SPI_EN) else $error("halted not ready");
    a_halt_bound:
    assert property (halt_cnt_ff <= HALT_CYC + 2) else $error("halt too long");
    a_resume_order:
    assert property ($fell(O_HALTED) |-> !ready_on ##[1:2] !O_SPI_EN) else $error("resume order");
    a_supply_cause:
    assert property ($rose(O_SUPPLY_SWITCH_ON) |-> $past(I_PERIOD_DONE && I_ATTN && I_CFG.supply_en && O_SLEEP))
        else $error("supply cause");
    a_pwm_idle:
    assert property ((O_SLEEP && $stable(I_CFG))[*3] |-> O_PWM != I_CFG.pwm_pol) else $error("pwm idle");
    a_notify_idle:
    assert property ((O_SLEEP && $stable(I_CFG))[*3] |-> !ready_on) else $error("notify idle");

    c_halt: cover property ($rose(O_HALTED));
    c_clear: cover property ($fell(O_HALTED) && O_SPI_EN);
    c_supply: cover property ($rose(O_SUPPLY_SWITCH_ON));
endmodule

// ==== verification/test_prha_top.sv ====
module test_prha_top
    import prha_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HALT_SIM = 2000;

    logic       clk, rst_n, s_valid, done, attn, cs_n, sclk, mosi, ok;
    logic       o_pwm, o_notify, o_supply, o_spi_en, o_sleep, o_halted, o_miso;
    logic [9:0] s_code;
    logic [7:0] o_idx, exp_idx;
    logic [15:0] rx;
    prha_cfg_t  cfg;
    prha_err_t  err;
    int         n_mismatch, n_tests, k;

    prha_top #(.HALT_CYC(HALT_SIM), .SUPPLY_CYC(200), .PULSE_CYC(50)) i_dut (
        .I_CLK(clk), .I_RST_N(rst_n), .I_CFG(cfg), .I_ERR(err), .I_SAMPLE_VALID(s_valid),
        .I_SAMPLE_CODE(s_code), .I_PERIOD_DONE(done), .I_ATTN(attn), .I_CS_N(cs_n), .I_SCLK(sclk),
        .I_MOSI(mosi), .O_PWM(o_pwm), .O_NOTIFY(o_notify), .O_SUPPLY_SWITCH_ON(o_supply),
        .O_SPI_EN(o_spi_en), .O_SLEEP(o_sleep), .O_HALTED(o_halted), .O_MISO(o_miso), .O_BUF_LAST_IDX(o_idx));

    prha_host_model i_host (.i_miso(o_miso), .i_ready_pin(o_notify), .i_ready_pol(cfg.notify_pol),
        .o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask

    function automatic logic [9:0] code(input int i);
        return 10'h0F0 + 10'h02D * 10'(i);
    endfunction

    // One sample, index judged a cycle later
    task automatic push(input int i);
        s_code = code(i);
        s_valid = 1'b1;
        step(1);
        s_valid = 1'b0;
        step(1);
        if (!o_halted) exp_idx = (exp_idx == 8'h8D) ? 8'h77 : exp_idx + 8'h02;
        chk("buffer index", 16'(exp_idx), 16'(o_idx));
    endtask

    task automatic frames(input logic [15:0] tx[], input logic [15:0] ex[]);
        foreach (tx[j]) begin
            i_host.xfer(tx[j], rx);
            chk("spi answer", ex[j], rx);
        end
    endtask

    task automatic t_normal_clear();
        cfg = '{supply_en: 1'b0, pwm_pol: 1'b1, notify_pol: 1'b0, normal_mode: 1'b1};
        push(0);
        push(1);
        done = 1'b1;
        step(1);
        done = 1'b0;
        step(20);
        chk("sleep left", 16'h0, 16'(o_sleep));
        chk("pwm active", 16'h1, 16'(o_pwm));
        i_host.wake(ok);
        chk("ready seen", 16'h1, 16'(ok));
        chk("halted", 16'h1, 16'(o_halted));
        push(5);
        frames('{16'h7600, 16'h2001, 16'h7800, 16'h7900, 16'h7A00, 16'h2100, 16'h2000},
               '{16'h0000, 16'h0000, 16'h2005, 16'h7801, 16'h791D, 16'h7A00, 16'h2179});
        for (k = 0; k < 20 && o_halted !== 1'b0; k++) step(1);
        chk("ready dropped", 16'h1, 16'(o_notify));
        step(3);
        chk("port off", 16'h0, 16'(o_spi_en));
        chk("back asleep", 16'h1, 16'(o_sleep));
        $display("normal access test done");
    endtask

    task automatic t_event_timeout();
        for (int i = 2; i < 13; i++) push(i);
        cfg = '{supply_en: 1'b1, pwm_pol: 1'b0, notify_pol: 1'b1, normal_mode: 1'b0};
        step(4);
        done = 1'b1;
        attn = 1'b1;
        step(1);
        done = 1'b0;
        attn = 1'b0;
        step(1);
        chk("supply on", 16'h1, 16'(o_supply));
        for (k = 0; k < 400 && o_notify !== 1'b1; k++) step(1);
        chk("supply wait", 16'h1, 16'(k > 150));
        for (k = 0; k < 200 && o_notify !== 1'b0; k++) step(1);
        for (k = 0; k < 20 && o_pwm !== 1'b0; k++) step(1);
        chk("event pwm", 16'h0, 16'(o_pwm));
        i_host.wake(ok);
        chk("ready seen", 16'h1, 16'(ok));
        chk("pwm stopped", 16'h1, 16'(o_pwm));
        frames('{16'h7600, 16'h8D00, 16'h2100, 16'h2100},
               '{16'h0000, 16'h0000, 16'h8DDF, 16'h2177});
        for (k = 0; k < HALT_SIM + 100 && o_halted !== 1'b0; k++) step(1);
        chk("timed out", 16'h0, 16'(o_halted));
        chk("ready idle", 16'h0, 16'(o_notify));
        step(3);
        chk("asleep", 16'h1, 16'(o_sleep));
        chk("supply off", 16'h0, 16'(o_supply));
        $display("event timeout test done");
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #100us;
        n_mismatch++;
        summarize();
    end

    initial begin
        n_mismatch = 0;
        n_tests = 0;
        rst_n = 1'b0;
        cfg = '0;
        err = '0;
        s_valid = 1'b0;
        s_code = '0;
        done = 1'b0;
        attn = 1'b0;
        exp_idx = 8'h8D;
        step(4);
        rst_n = 1'b1;
        step(4);
        chk("reset index", 16'h008D, 16'(o_idx));
        chk("reset sleep", 16'h1, 16'(o_sleep));
        $display("reset test done");
        t_normal_clear();
        t_event_timeout();
        summarize();
    end
endmodule

bind prha_top prha_monitor #(.HALT_CYC(HALT_CYC)) i_mon (
    .I_CLK, .I_RST_N, .I_CFG, .I_SAMPLE_VALID, .I_PERIOD_DONE, .I_ATTN, .O_PWM, .O_NOTIFY,
    .O_SUPPLY_SWITCH_ON, .O_SPI_EN, .O_SLEEP, .O_HALTED, .O_BUF_LAST_IDX);
